/* dv/pieb_core_model.sv */
module pieb_core_model (
	// clock and reset
	input  logic       clk_in,
	input  logic       sys_rst_in,
	// request seen from the block, handler length
	input  logic       vec_req_in,
	input  logic [3:0] delay_in,
	// vector accept and return
	output logic       ack_out,
	output logic       ret_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_r;
	logic       busy_r;
	// accept only a request still standing, then return after the handler
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		ret_out <= 1'b0;
		if (sys_rst_in) begin
			cnt_r  <= 4'h0;
			busy_r <= 1'b0;
		end else if (busy_r || vec_req_in) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == delay_in) begin
				cnt_r   <= 4'h0;
				busy_r  <= !busy_r;
				ack_out <= !busy_r;
				ret_out <= busy_r;
			end
		end
	end
endmodule

/* dv/pieb_properties.sv */
module pieb_chk (
	// clock and reset
	input logic       clk_in,
	input logic       sys_rst_in,
	// register port
	input logic [3:0] addr_in,
	input logic       wr_in,
	input logic       rd_in,
	input logic [7:0] rdata_out,
	// core side
	input logic       vector_ack_in,
	input logic       int_return_in,
	input logic       periph_req_out,
	input logic       core_vector_req_out,
	input logic       global_int_en_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	rdata_idle_a: assert property (
		!$past(rd_in) |-> rdata_out == 8'h00) else $error("stray read data");
	unmapped_zero_a: assert property (
		$past(rd_in) && $past(addr_in) > 4'h8 |-> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	bank1_gaps_a: assert property (
		$past(rd_in) && ($past(addr_in) == 4'h1 || $past(addr_in) == 4'h4)
		|-> rdata_out[5:4] == 2'h0 && !rdata_out[2])
		else $error("bank one gap bits set");
	bank3_gaps_a: assert property (
		$past(rd_in) && ($past(addr_in) == 4'h3 || $past(addr_in) == 4'h6)
		|-> rdata_out[7:2] == 6'h00) else $error("bank three gap bits set");
	vec_gated_a: assert property (
		core_vector_req_out |-> periph_req_out)
		else $error("vector without peripheral request");
	ack_clears_a: assert property (
		vector_ack_in && core_vector_req_out
		|=> !global_int_en_out && !core_vector_req_out)
		else $error("accept did not drop global enable");
	ret_sets_a: assert property (
		int_return_in && !vector_ack_in && !wr_in |=> global_int_en_out)
		else $error("return did not set global enable");
	req_fall_a: assert property (
		$fell(periph_req_out) |-> $past(wr_in) || $past(wr_in, 2) ||
		$past(sys_rst_in))
		else $error("request dropped without a write");
endmodule

bind pieb_top pieb_chk u_chk (.clk_in, .sys_rst_in, .addr_in, .wr_in,
	.rd_in, .rdata_out, .vector_ack_in, .int_return_in, .periph_req_out,
	.core_vector_req_out, .global_int_en_out);

/* dv/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 0;
	logic        sys_rst_in = 1;
	logic [3:0]  addr_r = 0;
	logic [7:0]  wdata_r = 0;
	logic        wr_r = 0;
	logic        rd_r = 0;
	logic [10:0] evt_r = 0;
	logic [7:0]  rdata_out;
	logic        periph_req_out;
	logic        core_vector_req_out;
	logic        global_int_en_out;
	logic        irq_out;
	logic        ack;
	logic        ret;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          i;
	logic [7:0]  m [3] = '{8'hCB, 8'h6C, 8'h03};

	pieb_top DUT (.clk_in, .sys_rst_in, .addr_in(addr_r),
		.wdata_in(wdata_r), .wr_in(wr_r), .rd_in(rd_r), .rdata_out,
		.tmr_a_gate_evt_in(evt_r[10]), .adc_done_evt_in(evt_r[9]),
		.serial_port_evt_in(evt_r[8]), .tmr_b_match_evt_in(evt_r[7]),
		.tmr_a_ovf_evt_in(evt_r[6]), .comparator_two_evt_in(evt_r[5]),
		.comparator_one_evt_in(evt_r[4]), .bus_collision_evt_in(evt_r[3]),
		.osc_accum_evt_in(evt_r[2]), .logic_cell_two_evt_in(evt_r[1]),
		.logic_cell_one_evt_in(evt_r[0]), .vector_ack_in(ack),
		.int_return_in(ret), .periph_req_out, .core_vector_req_out,
		.global_int_en_out, .irq_out);
	pieb_core_model u_core (.clk_in, .sys_rst_in,
		.vec_req_in(core_vector_req_out), .delay_in(4'h8),
		.ack_out(ack), .ret_out(ret));

	initial forever #2 clk_in = ~clk_in;

	task results;
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			results;
		end
	end

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	// one strobe cycle; events ride beside it to hit the same edge
	task op(input w, input [3:0] a, input [7:0] d, input [10:0] v);
		@(posedge clk_in);
		wr_r <= w;
		addr_r <= a;
		wdata_r <= d;
		evt_r <= v;
		@(posedge clk_in);
		wr_r <= 0;
		evt_r <= 0;
	endtask

	task rd(input [3:0] a, input [7:0] e);
		@(posedge clk_in);
		rd_r <= 1;
		addr_r <= a;
		@(posedge clk_in);
		rd_r <= 0;
		#1 chk("rdata", e, rdata_out);
	endtask

	task tick;
		@(posedge clk_in);
		#1;
	endtask

	initial begin
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 0;
		for (i = 0; i < 9; i++) rd(i[3:0], 8'h00);
		op(1, 4'hF, 8'hFF, '0);
		rd(4'hF, 8'h00);
		for (i = 0; i < 3; i++) begin
			op(1, 4'(i + 1), 8'hFF, '0);
			rd(4'(i + 1), m[i]);
			op(1, 4'(i + 1), 8'h00, '0);
		end
		op(0, 0, 0, 11'h7FF);
		tick;
		chk("req", 0, periph_req_out);
		for (i = 0; i < 3; i++) begin
			rd(4'(i + 4), m[i]);
			op(1, 4'(i + 4), 8'h00, '0);
			rd(4'(i + 4), 8'h00);
		end
		op(1, 1, 8'hFF, '0);
		sys_rst_in <= 1;
		@(posedge clk_in);
		sys_rst_in <= 0;
		rd(1, 8'h00);
		op(1, 0, 8'h40, '0);
		op(1, 1, 8'h01, '0);
		op(0, 0, 0, 11'h040);
		tick;
		chk("req", 1, periph_req_out);
		chk("vec", 0, core_vector_req_out);
		op(1, 0, 8'h00, '0);
		tick;
		chk("req", 0, periph_req_out);
		op(1, 0, 8'hC0, '0);
		for (i = 0; i < 40 && !ack; i++) tick;
		chk("vec", 1, core_vector_req_out);
		repeat (2) tick;
		chk("gie", 0, global_int_en_out);
		op(1, 4, 8'h00, '0);
		for (i = 0; i < 40 && !ret; i++) tick;
		repeat (2) tick;
		chk("gie", 1, global_int_en_out);
		chk("vec", 0, core_vector_req_out);
		rd(0, 8'hC0);
		chk("irq", 0, irq_out);
		op(1, 8, 8'h02, '0);
		tick;
		chk("irq", 1, irq_out);
		rd(7, 8'h03);
		tick;
		chk("irq", 0, irq_out);
		op(1, 4, 8'h00, 11'h400);
		rd(4, 8'h80);
		op(0, 0, 0, 11'h400);
		op(1, 1, 8'h81, '0);
		rd(7, 8'h0D);
		results;
	end
endmodule

/* hw/pieb_consts.vh */
`ifndef PIEB_CONSTS_VH
`define PIEB_CONSTS_VH

// register bus geometry
`define PIEB_AW            4
`define PIEB_DW            8

// register offsets
`define PIEB_OFF_CORE_CTL  4'h0
`define PIEB_OFF_EN1       4'h1
`define PIEB_OFF_EN2       4'h2
`define PIEB_OFF_EN3       4'h3
`define PIEB_OFF_REQ1      4'h4
`define PIEB_OFF_REQ2      4'h5
`define PIEB_OFF_REQ3      4'h6
`define PIEB_OFF_IRQ_STAT  4'h7
`define PIEB_OFF_IRQ_MASK  4'h8

// implemented-bit masks; bank masks shared by enable and flag registers, IRQ mask for status and mask registers, CORE unused
`define PIEB_MASK_BANK1    8'hCB
`define PIEB_MASK_BANK2    8'h6C
`define PIEB_MASK_BANK3    8'h03
`define PIEB_MASK_CORE     8'hC0
`define PIEB_MASK_IRQ      8'h0F

// bank 1 fields
`define PIEB_B1_TMR_A_GATE 7
`define PIEB_B1_ADC_DONE   6
`define PIEB_B1_SERIAL     3
`define PIEB_B1_TMR_B      1
`define PIEB_B1_TMR_A_OVF  0

// bank 2 fields
`define PIEB_B2_CMP_TWO    6
`define PIEB_B2_CMP_ONE    5
`define PIEB_B2_BUS_COLL   3
`define PIEB_B2_OSC_ACC    2

// bank 3 fields
`define PIEB_B3_CELL_TWO   1
`define PIEB_B3_CELL_ONE   0

// core interrupt control fields
`define PIEB_CORE_GIE      7
`define PIEB_CORE_PERIPH_GROUP_EN     6

// block event status fields
`define PIEB_EV_REQ_RISE   0
`define PIEB_EV_VECTOR     1
`define PIEB_EV_OVERRUN    2
`define PIEB_EV_STALE      3

// reset values
`define PIEB_RST_BYTE      8'h00

`endif

/* hw/pieb_en_reg.v */
`include "pieb_consts.vh"

module pieb_en_reg #(
	parameter [7:0] IMPL_MASK = 8'hFF
) (
	// clock and reset
	input  wire       clk_in,
	input  wire       sys_rst_in,
	// software write
	input  wire       wr_in,
	input  wire [7:0] wdata_in,
	// stored value
	output reg  [7:0] value_out
);

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			value_out <= `PIEB_RST_BYTE;
		end else if (wr_in) begin
			// unimplemented positions never store
			value_out <= wdata_in & IMPL_MASK;
		end
	end

endmodule

/* hw/pieb_flag_reg.v */
`include "pieb_consts.vh"

module pieb_flag_reg #(
	parameter [7:0] IMPL_MASK = 8'hFF
) (
	// clock and reset
	input  wire       clk_in,
	input  wire       sys_rst_in,
	// hardware set events, one bit per source
	input  wire [7:0] set_in,
	// software write
	input  wire       wr_in,
	input  wire [7:0] wdata_in,
	// stored flags
	output reg  [7:0] value_out
);

	reg [7:0] value_nxt;

	always @* begin
		value_nxt = value_out;
		if (wr_in) begin
			value_nxt = wdata_in;
		end
		// hardware set beats a same-cycle software clear
		value_nxt = (value_nxt | set_in) & IMPL_MASK;
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			value_out <= `PIEB_RST_BYTE;
		end else begin
			value_out <= value_nxt;
		end
	end

endmodule

/* hw/pieb_top.v */
`include "pieb_consts.vh"

// Notes on behaviour
// - no peripheral request without group enable
// - first enable register bit layout
// - second enable register bit layout
// - third enable register: two cell enables
// - first flag register bit layout
// - flags set regardless of any enable
// - flag one means pending; software clears
// - every implemented bit resets to zero
// - unimplemented bits read back zero
// - enable gates request, never the flag
// - vector only while global enable set
// - group enable sits at control bit six
module pieb_top (
	// clock and reset
	input  wire                clk_in,
	input  wire                sys_rst_in,
	// register port
	input  wire [`PIEB_AW-1:0] addr_in,
	input  wire [`PIEB_DW-1:0] wdata_in,
	input  wire                wr_in,
	input  wire                rd_in,
	output reg  [`PIEB_DW-1:0] rdata_out,
	// peripheral events, bank 1
	input  wire                tmr_a_gate_evt_in,
	input  wire                adc_done_evt_in,
	input  wire                serial_port_evt_in,
	input  wire                tmr_b_match_evt_in,
	input  wire                tmr_a_ovf_evt_in,
	// peripheral events, bank 2
	input  wire                comparator_two_evt_in,
	input  wire                comparator_one_evt_in,
	input  wire                bus_collision_evt_in,
	input  wire                osc_accum_evt_in,
	// peripheral events, bank 3
	input  wire                logic_cell_two_evt_in,
	input  wire                logic_cell_one_evt_in,
	// processor core handshake
	input  wire                vector_ack_in,
	input  wire                int_return_in,
	output reg                 periph_req_out,
	output reg                 core_vector_req_out,
	output reg                 global_int_en_out,
	// block interrupt
	output reg                 irq_out
);

	// register decode, used for every write strobe and the status read strobe
	function hit;
		input [`PIEB_AW-1:0] a;
		input [`PIEB_AW-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// per-source pending term of one bank
	function [7:0] pend;
		input [7:0] flags;
		input [7:0] ens;
		begin
			pend = flags & ens;
		end
	endfunction

	// event on a flag that is already up
	function over;
		input [7:0] sets;
		input [7:0] flags;
		begin
			over = |(sets & flags);
		end
	endfunction

	// enable raised on a source whose flag is still pending
	function stale;
		input       wr;
		input [7:0] wd;
		input [7:0] ens;
		input [7:0] flags;
		begin
			stale = wr & |(wd & ~ens & flags);
		end
	endfunction

	wire [7:0] en1;
	wire [7:0] en2;
	wire [7:0] en3;
	wire [7:0] req1;
	wire [7:0] req2;
	wire [7:0] req3;
	reg  [7:0] set1;
	reg  [7:0] set2;
	reg  [7:0] set3;

	reg        global_int_en_r;
	reg        periph_group_en_r;
	reg        global_int_en_nxt;
	reg        periph_group_en_nxt;
	reg  [7:0] irq_stat_r;
	reg  [7:0] irq_stat_nxt;
	reg  [7:0] irq_mask_r;
	reg  [7:0] rdata_nxt;
	reg  [7:0] irq_ev;
	reg        periph_req_nxt;
	reg        periph_req_prev_r;

	wire wr_core = wr_in & hit(addr_in, `PIEB_OFF_CORE_CTL);
	wire wr_en1  = wr_in & hit(addr_in, `PIEB_OFF_EN1);
	wire wr_en2  = wr_in & hit(addr_in, `PIEB_OFF_EN2);
	wire wr_en3  = wr_in & hit(addr_in, `PIEB_OFF_EN3);
	wire wr_req1 = wr_in & hit(addr_in, `PIEB_OFF_REQ1);
	wire wr_req2 = wr_in & hit(addr_in, `PIEB_OFF_REQ2);
	wire wr_req3 = wr_in & hit(addr_in, `PIEB_OFF_REQ3);
	wire wr_mask = wr_in & hit(addr_in, `PIEB_OFF_IRQ_MASK);
	// only the status register has a read side effect
	wire rd_stat = rd_in & hit(addr_in, `PIEB_OFF_IRQ_STAT);

	// event sources share the system clock, so no synchroniser
	always @* begin
		set1 = `PIEB_RST_BYTE;
		set1[`PIEB_B1_TMR_A_GATE] = tmr_a_gate_evt_in;
		set1[`PIEB_B1_ADC_DONE] = adc_done_evt_in;
		set1[`PIEB_B1_SERIAL] = serial_port_evt_in;
		set1[`PIEB_B1_TMR_B] = tmr_b_match_evt_in;
		set1[`PIEB_B1_TMR_A_OVF] = tmr_a_ovf_evt_in;
	end

	always @* begin
		set2 = `PIEB_RST_BYTE;
		set2[`PIEB_B2_CMP_TWO] = comparator_two_evt_in;
		set2[`PIEB_B2_CMP_ONE] = comparator_one_evt_in;
		set2[`PIEB_B2_BUS_COLL] = bus_collision_evt_in;
		set2[`PIEB_B2_OSC_ACC] = osc_accum_evt_in;
	end

	always @* begin
		set3 = `PIEB_RST_BYTE;
		set3[`PIEB_B3_CELL_TWO] = logic_cell_two_evt_in;
		set3[`PIEB_B3_CELL_ONE] = logic_cell_one_evt_in;
	end

	// enable registers
	pieb_en_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK1)
	) u_en1 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.wr_in      (wr_en1),
		.wdata_in   (wdata_in),
		.value_out  (en1)
	);

	pieb_en_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK2)
	) u_en2 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.wr_in      (wr_en2),
		.wdata_in   (wdata_in),
		.value_out  (en2)
	);

	pieb_en_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK3)
	) u_en3 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.wr_in      (wr_en3),
		.wdata_in   (wdata_in),
		.value_out  (en3)
	);

	// request flag registers, software clears by writing zero
	pieb_flag_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK1)
	) u_req1 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.set_in     (set1),
		.wr_in      (wr_req1),
		.wdata_in   (wdata_in),
		.value_out  (req1)
	);

	pieb_flag_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK2)
	) u_req2 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.set_in     (set2),
		.wr_in      (wr_req2),
		.wdata_in   (wdata_in),
		.value_out  (req2)
	);

	pieb_flag_reg #(
		.IMPL_MASK (`PIEB_MASK_BANK3)
	) u_req3 (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.set_in     (set3),
		.wr_in      (wr_req3),
		.wdata_in   (wdata_in),
		.value_out  (req3)
	);

	// peripheral request, gated by the group enable
	always @* begin
		periph_req_nxt = |pend(req1, en1);
		periph_req_nxt = periph_req_nxt | |pend(req2, en2);
		periph_req_nxt = periph_req_nxt | |pend(req3, en3);
		// group enable gates every source
		periph_req_nxt = periph_req_nxt & periph_group_en_r;
	end

	// core control: entry clears global enable, return sets it
	always @* begin
		global_int_en_nxt = global_int_en_r;
		periph_group_en_nxt = periph_group_en_r;
		if (wr_core) begin
			global_int_en_nxt = wdata_in[`PIEB_CORE_GIE];
			periph_group_en_nxt = wdata_in[`PIEB_CORE_PERIPH_GROUP_EN];
		end
		if (int_return_in) begin
			global_int_en_nxt = 1'b1;
		end
		// entry wins so a late return cannot reopen nesting
		if (vector_ack_in & core_vector_req_out) begin
			global_int_en_nxt = 1'b0;
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			global_int_en_r <= 1'b0;
			periph_group_en_r <= 1'b0;
		end else begin
			global_int_en_r <= global_int_en_nxt;
			periph_group_en_r <= periph_group_en_nxt;
		end
	end

	// block events: request rise, vector taken, overrun, stale enable
	always @* begin
		irq_ev = 8'h00;
		irq_ev[`PIEB_EV_REQ_RISE] = periph_req_nxt & ~periph_req_prev_r;
		irq_ev[`PIEB_EV_VECTOR] = vector_ack_in & core_vector_req_out;
		irq_ev[`PIEB_EV_OVERRUN] = over(set1, req1) |
			over(set2, req2) | over(set3, req3);
		// enabling a source whose flag is still up
		irq_ev[`PIEB_EV_STALE] = stale(wr_en1, wdata_in, en1, req1) |
			stale(wr_en2, wdata_in, en2, req2) |
			stale(wr_en3, wdata_in, en3, req3);
	end

	// status clears on read; an event in the read cycle survives
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (rd_stat) begin
			irq_stat_nxt = 8'h00;
		end
		irq_stat_nxt = (irq_stat_nxt | irq_ev) & `PIEB_MASK_IRQ;
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_stat_r <= `PIEB_RST_BYTE;
			irq_mask_r <= `PIEB_RST_BYTE;
			periph_req_prev_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			periph_req_prev_r <= periph_req_nxt;
			if (wr_mask) begin
				irq_mask_r <= wdata_in & `PIEB_MASK_IRQ;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		rdata_nxt = 8'h00;
		if (rd_in) begin
			case (addr_in)
			`PIEB_OFF_CORE_CTL: begin
				rdata_nxt[`PIEB_CORE_GIE] = global_int_en_r;
				rdata_nxt[`PIEB_CORE_PERIPH_GROUP_EN] = periph_group_en_r;
			end
			`PIEB_OFF_EN1: begin
				rdata_nxt = en1;
			end
			`PIEB_OFF_EN2: begin
				rdata_nxt = en2;
			end
			`PIEB_OFF_EN3: begin
				rdata_nxt = en3;
			end
			`PIEB_OFF_REQ1: begin
				rdata_nxt = req1;
			end
			`PIEB_OFF_REQ2: begin
				rdata_nxt = req2;
			end
			`PIEB_OFF_REQ3: begin
				rdata_nxt = req3;
			end
			`PIEB_OFF_IRQ_STAT: begin
				rdata_nxt = irq_stat_r;
			end
			`PIEB_OFF_IRQ_MASK: begin
				rdata_nxt = irq_mask_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
			endcase
		end
	end

	// outputs all registered; request lags the flag by one cycle
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_out <= `PIEB_RST_BYTE;
			periph_req_out <= 1'b0;
			core_vector_req_out <= 1'b0;
			global_int_en_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			rdata_out <= rdata_nxt;
			periph_req_out <= periph_req_nxt;
			// held off while global enable is clear, served later
			core_vector_req_out <= periph_req_nxt & global_int_en_nxt;
			global_int_en_out <= global_int_en_nxt;
			// a mask write shows on irq one cycle after it lands
			irq_out <= |(irq_stat_nxt & irq_mask_r);
		end
	end

endmodule
